// File: include/dpr_pkg.sv
// shared constants and carriers for the dual-port memory port host
// Function
// RL1 - Device offers 32K x 18 words on two independent ports.
// RL2 - Port selected only with low select low and high select high.
// RL3 - Write: rw low, flag space high; lane selects pick bits 9-17, 0-8.
// RL4 - Read: rw high, output enable low; only selected lanes driven.
// RL5 - Both ports may read one location at once correctly.
// RL6 - Role select high makes contention flag output, low makes it input.
// RL7 - Contention and interrupt flags are always push-pull, never floated.
// RL8 - Wide words: devices side by side, one master, rest slave.
// RL9 - Depth expansion decodes upper address onto opposite-polarity selects.
// RL10 - Output enable or both lanes high floats data; no word changes.
// RL11 - Host avoids writing a location the other port is using; this host has no such guard, the caller orders it.
// RL12 - Eight flags at address bits 0-2, written from bit 0, read on all.
package dpr_pkg;

  // ==========================================================
  // geometry
  localparam int ADDR_W  = 15;
  localparam int DATA_W  = 18;
  localparam int LANE_W  = 9;
  localparam int LANES   = 2;
  localparam int UPPER   = 1;   // lane index of bits 9-17
  localparam int LOWER   = 0;   // lane index of bits 0-8

  // ==========================================================
  // timing
  localparam int CLK_NS      = 10;
  localparam int ACCESS_NS   = 20;
  localparam int ACCESS_CYC  = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_STAGES = 2;
  localparam int STROBE_CYC  = ACCESS_CYC + SYNC_STAGES;
  localparam int CNT_W       = 4;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic              write;
    logic              flag;    // flag space access
    logic              bank;    // upper address bit for depth expansion
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  lanes;   // high = lane used
    logic [DATA_W-1:0] wdata;
  } dpr_req_s;

  typedef struct packed {
    logic              sel_low_n;
    logic              sel_high;
    logic              rw;
    logic              oe_n;
    logic              upper_n;
    logic              lower_n;
    logic              flag_n;
    logic [ADDR_W-1:0] addr;
  } dpr_pin_s;

  localparam dpr_pin_s PIN_IDLE = '{sel_low_n: 1'b1, sel_high: 1'b0, rw: 1'b1, oe_n: 1'b1,
                                    upper_n: 1'b1, lower_n: 1'b1, flag_n: 1'b1, addr: '0};

  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_RECOVER} dpr_state_e;

endpackage

// File: rtl/dpr_port_host.sv
// host controller that drives one port of the dual-port memory
`timescale 1ns/1ps
module dpr_port_host #(
  parameter bit IS_MASTER = 1'b1
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  // user side
  input  wire logic                          req_valid,
  input  wire dpr_pkg::dpr_req_s             req,
  output logic                               req_ready,
  output logic                               done,
  output logic [dpr_pkg::DATA_W-1:0]         rdata,
  output logic                               irq,
  // pins toward the memory port
  output dpr_pkg::dpr_pin_s                  pin,
  input  wire logic [dpr_pkg::DATA_W-1:0]    data_in,
  output logic [dpr_pkg::DATA_W-1:0]         data_out,
  output logic [dpr_pkg::LANES-1:0]          data_oe_n,
  output logic                               role,
  input  wire logic                          busy_n_in,
  output logic                               busy_n_out,
  output logic                               busy_oe_n,
  input  wire logic                          int_n_in
);

  // ==========================================================
  // pin synchronisers
  logic [dpr_pkg::DATA_W-1:0] data_s1;
  logic [dpr_pkg::DATA_W-1:0] data_s2;
  logic                       busy_s1;
  logic                       busy_s2;
  logic                       int_s1;
  logic                       int_s2;

  // all input pins are asynchronous to clk, two flops each
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      data_s1 <= '0;
      data_s2 <= '0;
      busy_s1 <= 1'b1;
      busy_s2 <= 1'b1;
      int_s1  <= 1'b1;
      int_s2  <= 1'b1;
    end
    else
    begin
      data_s1 <= data_in;
      data_s2 <= data_s1;
      busy_s1 <= busy_n_in;
      busy_s2 <= busy_s1;
      int_s1  <= int_n_in;
      int_s2  <= int_s1;
    end
  end

  // ==========================================================
  // sequencing
  dpr_pkg::dpr_state_e       state;
  dpr_pkg::dpr_state_e       next_state;
  dpr_pkg::dpr_req_s         cur;
  dpr_pkg::dpr_req_s         next_cur;
  logic [dpr_pkg::CNT_W-1:0] cnt;
  logic [dpr_pkg::CNT_W-1:0] next_cnt;
  logic                      take;
  logic                      no_lane;
  logic                      busy_wait;
  logic                      strobe_last;

  // no guard against the far port using the same word; the caller orders that
  assign take        = req_valid && req_ready;                                 // [RL11]
  // both lanes off on a normal access stores nothing, so skip it
  assign no_lane     = !req.flag && (req.lanes == 2'h0);                       // [RL10]
  // only a master drives the contention flag toward us
  assign busy_wait   = IS_MASTER && !busy_s2;                                  // [RL6]
  assign strobe_last = (cnt == dpr_pkg::CNT_W'(dpr_pkg::STROBE_CYC - 1)) && !busy_wait;
  assign next_cur    = take ? req : cur;

  // state transitions
  always_comb
  begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      dpr_pkg::ST_IDLE:
      begin
        if (take)
          next_state = no_lane ? dpr_pkg::ST_RECOVER : dpr_pkg::ST_SETUP;
      end
      dpr_pkg::ST_SETUP:
      begin
        next_state = dpr_pkg::ST_STROBE;
        next_cnt   = '0;
      end
      dpr_pkg::ST_STROBE:
      begin
        if (strobe_last)
          next_state = dpr_pkg::ST_RECOVER;
        else if (!busy_wait)
          next_cnt = cnt + 4'h1;
      end
      dpr_pkg::ST_RECOVER:
        next_state = dpr_pkg::ST_IDLE;
      default:
        next_state = dpr_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= dpr_pkg::ST_IDLE;
      cnt   <= '0;
      cur   <= '0;
    end
    else
    begin
      state <= next_state;
      cnt   <= next_cnt;
      cur   <= next_cur;
    end
  end

  // ==========================================================
  // pin decode from the next state, so pins leave flops directly
  logic                       n_active;
  logic                       n_strobe;
  logic                       n_drive;
  logic                       n_mem;
  dpr_pkg::dpr_pin_s          next_pin;
  logic [dpr_pkg::LANES-1:0]  next_data_oe_n;
  logic [dpr_pkg::DATA_W-1:0] next_rdata;
  logic [dpr_pkg::DATA_W-1:0] lane_mask;

  assign n_active = (next_state == dpr_pkg::ST_SETUP) || (next_state == dpr_pkg::ST_STROBE);
  assign n_strobe = (next_state == dpr_pkg::ST_STROBE);
  // write data held one cycle past rw rising for hold time
  assign n_drive  = next_cur.write && (n_active || (next_state == dpr_pkg::ST_RECOVER && state != dpr_pkg::ST_IDLE));
  assign n_mem    = n_active && !next_cur.flag;

  // selects: bank bit feeds low select of one device and high of the other
  assign next_pin.sel_low_n = n_mem ? next_cur.bank : 1'b1;                    // [RL2] [RL9]
  assign next_pin.sel_high  = n_mem ? next_cur.bank : 1'b0;                    // [RL2] [RL9]
  assign next_pin.flag_n    = !(n_active && next_cur.flag);                    // [RL12]
  assign next_pin.rw        = !(n_strobe && next_cur.write);                   // [RL3]
  assign next_pin.oe_n      = !(n_strobe && !next_cur.write);                  // [RL4]
  // flag accesses leave both lanes off, the chip selects are off anyway
  assign next_pin.upper_n   = !(n_mem && next_cur.lanes[dpr_pkg::UPPER]);      // [RL3] [RL4]
  assign next_pin.lower_n   = !(n_mem && next_cur.lanes[dpr_pkg::LOWER]);      // [RL3] [RL4]
  assign next_pin.addr      = next_cur.addr;

  // drive only the lanes being written; flag writes drive all pins
  genvar g;
  generate
    for (g = 0; g < dpr_pkg::LANES; g++)
    begin : g_lane
      assign next_data_oe_n[g] = !(n_drive && (next_cur.flag || next_cur.lanes[g]));  // [RL3] [RL12]
      assign lane_mask[g*dpr_pkg::LANE_W +: dpr_pkg::LANE_W] = {dpr_pkg::LANE_W{cur.flag || cur.lanes[g]}};
    end
  endgenerate

  // unselected lanes float at the pins, so return them as zero
  assign next_rdata = data_s2 & lane_mask;                                     // [RL4] [RL12]

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pin       <= dpr_pkg::PIN_IDLE;
      data_oe_n <= '1;
      data_out  <= '0;
    end
    else
    begin
      pin       <= next_pin;
      data_oe_n <= next_data_oe_n;
      data_out  <= next_cur.wdata;
    end
  end

  // ==========================================================
  // user answers and flag pins
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      req_ready  <= 1'b0;
      done       <= 1'b0;
      rdata      <= '0;
      irq        <= 1'b0;
      role       <= 1'b0;
      busy_n_out <= 1'b1;
      busy_oe_n  <= 1'b1;
    end
    else
    begin
      req_ready  <= (next_state == dpr_pkg::ST_IDLE);
      done       <= (state == dpr_pkg::ST_RECOVER);
      if (state == dpr_pkg::ST_STROBE && strobe_last && !cur.write)
        rdata <= next_rdata;
      irq        <= !int_s2;
      role       <= IS_MASTER;                                                 // [RL6] [RL8]
      // a slave reads busy from us; report no contention
      busy_n_out <= 1'b1;
      busy_oe_n  <= IS_MASTER;                                                 // [RL6] [RL7]
    end
  end

  // ==========================================================
  // checks
  logic busy_clear;
  assign busy_clear = !busy_wait;

  sequence s_take_mem;
    req_valid && req_ready && !(!req.flag && req.lanes == 2'h0);
  endsequence

  sequence s_full_cycle;
    ##1 (pin.rw && pin.oe_n) ##1 (!pin.rw || !pin.oe_n)[*4] ##1 (pin.rw && pin.oe_n);
  endsequence

  chk_idle_standby: assert property (@(posedge clk) disable iff (rst)   // [RL2]
    (state == dpr_pkg::ST_IDLE) |-> (pin.sel_low_n && !pin.sel_high && pin.flag_n))
    else $error("port not in standby while idle");

  chk_flag_deselect: assert property (@(posedge clk) disable iff (rst)   // [RL12]
    !pin.flag_n |-> (pin.sel_low_n && !pin.sel_high && pin.upper_n && pin.lower_n))
    else $error("flag access with memory selected");

  chk_write_lanes: assert property (@(posedge clk) disable iff (rst)   // [RL3]
    (!pin.rw && pin.flag_n) |-> (data_oe_n == {pin.upper_n, pin.lower_n}))
    else $error("write drives wrong lanes");

  chk_read_float: assert property (@(posedge clk) disable iff (rst)   // [RL4]
    !pin.oe_n |-> (data_oe_n == 2'h3 && pin.rw))
    else $error("host drives data during read");

  chk_no_empty_write: assert property (@(posedge clk) disable iff (rst)   // [RL10]
    (!pin.rw && pin.flag_n) |-> !(pin.upper_n && pin.lower_n))
    else $error("write strobe with no lane");

  chk_strobe_length: assert property (@(posedge clk) disable iff (rst || !busy_clear)   // [RL3] [RL4]
    s_take_mem |-> s_full_cycle)
    else $error("strobe length wrong");

  chk_take_done: assert property (@(posedge clk) disable iff (rst || !busy_clear)   // [RL1]
    s_take_mem |-> ##7 (done && req_ready))
    else $error("access did not finish in seven cycles");

  chk_busy_dir: assert property (@(posedge clk) disable iff (rst)   // [RL6] [RL7]
    !$past(rst) |-> (busy_oe_n == IS_MASTER && role == IS_MASTER))
    else $error("contention flag direction wrong");

  chk_flag_write: assert property (@(posedge clk) disable iff (rst)   // [RL12]
    (!pin.rw && !pin.flag_n) |-> (data_oe_n == 2'h0))
    else $error("flag write not driving bit 0");

  chk_done_pulse: assert property (@(posedge clk) disable iff (rst)   // [RL1]
    done |=> !done)
    else $error("done longer than one cycle");

endmodule

// File: test/dpr_mem_model.sv
// behavioural model of one memory device on the host's port
`timescale 1ns/1ps
module dpr_mem_model (
  input  wire logic              clk,
  input  wire logic              sel_n,
  input  wire logic              sel,
  input  wire dpr_pkg::dpr_pin_s pin,
  input  wire logic [17:0]       bus,
  input  wire logic              role,
  input  wire logic              hold_busy,
  output logic [17:0]            dq,
  output logic [1:0]             dq_en,
  output logic                   busy_n
);
  // ==========================================================
  // storage and decode
  logic [17:0] mem [0:32767];
  logic [7:0]  flags = 8'h00;
  wire act = !sel_n && sel;
  wire rd  = act && pin.rw && !pin.oe_n && pin.flag_n;
  wire frd = !pin.flag_n && pin.rw && !pin.oe_n;

  // async read, so any number of ports may look at one word at once
  assign dq_en  = frd ? 2'b11 : (rd ? {!pin.upper_n, !pin.lower_n} : 2'b00);
  assign dq     = frd ? {18{flags[pin.addr[2:0]]}} : mem[pin.addr];
  // push-pull as master; as slave the host owns the line
  assign busy_n = role ? !hold_busy : 1'b1;

  // store per lane on every rising clock edge of an active write
  always @(posedge clk)
  begin
    if (act && !pin.rw && pin.flag_n)
    begin
      if (!pin.upper_n) mem[pin.addr][17:9] <= bus[17:9];
      if (!pin.lower_n) mem[pin.addr][8:0] <= bus[8:0];
    end
    if (!pin.flag_n && !pin.rw) flags[pin.addr[2:0]] <= bus[0];
  end
endmodule

// File: test/dual_port_ram_port_access_test.sv
// self-checking bench for the dual-port memory port host
`timescale 1ns/1ps
module dual_port_ram_port_access_test;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              req_valid = 1'b0;
  logic              hold_busy = 1'b0;
  logic              flt = 1'b0;
  logic              int_n = 1'b1;
  dpr_pkg::dpr_req_s req = '0;
  dpr_pkg::dpr_pin_s pin;
  logic              req_ready, done, irq, role, busy_n_out, busy_oe_n, busy0;
  logic [17:0]       rdata, data_out, bus, dq0, dq1, word;
  logic [1:0]        data_oe_n, en0, en1;
  int                err_count = 0, compares = 0, cyc = 0, n = 0;

  // undriven lanes toggle every cycle so stale data cannot pass
  assign bus[17:9] = !data_oe_n[1] ? data_out[17:9] : en0[1] ? dq0[17:9] : en1[1] ? dq1[17:9] : {9{flt}};
  assign bus[8:0]  = !data_oe_n[0] ? data_out[8:0] : en0[0] ? dq0[8:0] : en1[0] ? dq1[8:0] : {9{~flt}};

  dpr_port_host u_dpr_port_host (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .done(done), .rdata(rdata), .irq(irq), .pin(pin), .data_in(bus), .data_out(data_out), .data_oe_n(data_oe_n),
    .role(role), .busy_n_in(busy_oe_n ? busy0 : busy_n_out), .busy_n_out(busy_n_out), .busy_oe_n(busy_oe_n),
    .int_n_in(int_n));
  // two devices decoded by opposite select polarities
  dpr_mem_model u_bank0 (.clk(clk), .sel_n(pin.sel_low_n), .sel(1'b1), .pin(pin), .bus(bus), .role(role),
    .hold_busy(hold_busy), .dq(dq0), .dq_en(en0), .busy_n(busy0));
  dpr_mem_model u_bank1 (.clk(clk), .sel_n(1'b0), .sel(pin.sel_high), .pin(pin), .bus(bus), .role(1'b0),
    .hold_busy(1'b0), .dq(dq1), .dq_en(en1), .busy_n());

  // clock, float pattern and hang guard
  initial forever #5 clk = ~clk;
  always @(posedge clk)
  begin
    flt <= ~flt;
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("err_count=%0d compares=%0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [17:0] got, input logic [17:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
      err_count++;
    end
  endtask

  // one request; n counts cycles from take to done
  task automatic access(input logic wr, fl, bk, input logic [14:0] a, input logic [1:0] ln, input logic [17:0] wd);
    @(negedge clk);
    while (req_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{write: wr, flag: fl, bank: bk, addr: a, lanes: ln, wdata: wd};
    @(posedge clk);
    req_valid <= 1'b0;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (done !== 1'b1 && n < 40);
  endtask

  task automatic t_full();
    access(1, 0, 0, 15'h1234, 2'b11, 18'h2a5c3);
    check(18'(n), 18'd7, "write latency");
    access(0, 0, 0, 15'h1234, 2'b11, 18'h0);
    check(rdata, 18'h2a5c3, "full read");
    check(18'(n), 18'd7, "read latency");
  endtask

  task automatic t_lanes();
    word = {9'h0f1, 9'h1c3};
    access(1, 0, 0, 15'h1234, 2'b10, 18'h1e2ff);
    access(0, 0, 0, 15'h1234, 2'b01, 18'h0);
    check(rdata, {9'h0, word[8:0]}, "lower lane only");
    access(0, 0, 0, 15'h1234, 2'b10, 18'h0);
    check(rdata, {word[17:9], 9'h0}, "upper lane only");
    access(1, 0, 0, 15'h1234, 2'b00, 18'h3ffff);
    check(18'(n), 18'd2, "laneless request");
    access(0, 0, 0, 15'h1234, 2'b11, 18'h0);
    check(rdata, word, "word kept");
  endtask

  task automatic t_banks();
    access(1, 0, 1, 15'h1234, 2'b11, 18'h1b0b0);
    check(18'({pin.sel_low_n, pin.sel_high}), 18'h2, "idle deselect");
    access(0, 0, 1, 15'h1234, 2'b11, 18'h0);
    check(rdata, 18'h1b0b0, "upper bank read");
    access(0, 0, 0, 15'h1234, 2'b11, 18'h0);
    check(rdata, word, "lower bank untouched");
  endtask

  task automatic t_flags();
    access(1, 1, 0, 15'h0003, 2'b11, 18'h00001);
    access(1, 1, 0, 15'h0002, 2'b11, 18'h3fffe);
    access(0, 1, 0, 15'h0003, 2'b11, 18'h0);
    check(rdata, 18'h3ffff, "flag set");
    access(0, 1, 0, 15'h0002, 2'b11, 18'h0);
    check(rdata, 18'h0, "flag clear");
  endtask

  task automatic t_busy();
    check(18'({role, busy_oe_n, busy_n_out}), 18'h7, "master role");
    @(posedge clk);
    hold_busy <= 1'b1;
    fork
      access(0, 0, 0, 15'h1234, 2'b11, 18'h0);
      begin
        repeat (12) @(posedge clk);
        hold_busy <= 1'b0;
      end
    join
    check(18'(n > 7 && n < 30), 18'h1, "busy stretch");
    check(rdata, word, "read after busy");
  endtask

  task automatic t_irq();
    check(18'(irq), 18'h0, "irq idle");
    @(posedge clk);
    int_n <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check(18'(irq), 18'h1, "irq raised");
    @(posedge clk);
    int_n <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check(18'(irq), 18'h0, "irq cleared");
  endtask

  // main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_full();
    t_lanes();
    t_banks();
    t_flags();
    t_busy();
    t_irq();
    end_of_test();
  end
endmodule
